// ===== msd_addr_class.v
// Classifies one data-space address into its on-chip target
`include "msd_map.vh"
module msd_addr_class (
    input  wire [15:0] addr,
    input  wire        prog_ram_sel,
    input  wire        shared_ram_pin,
    input  wire [7:0]  global_low,
    output wire        hit_b0,
    output wire        hit_b1,
    output wire        hit_scr,
    output wire        hit_saram,
    output wire        hit_page0,
    output wire        is_global
);
    // Block zero answers in data space only while not lent to program
    assign hit_b0 = !prog_ram_sel && addr >= `MSD_B0_BASE &&
                    addr < `MSD_B0_BASE + `MSD_B_WORDS;
    assign hit_b1 = addr >= `MSD_B1_BASE &&
                    addr < `MSD_B1_BASE + `MSD_B_WORDS;
    assign hit_scr = addr >= `MSD_SCR_LO && addr <= `MSD_SCR_HI;
    assign hit_saram = shared_ram_pin && addr >= `MSD_SARAM_BASE &&
                  addr < `MSD_SARAM_BASE + `MSD_SARAM_WORDS;
    assign hit_page0 = addr <= `MSD_PAGE0_HI;
    // Global window: top byte against the size mask; a mask without its
    // top bit set leaves no global space at all
    assign is_global = global_low[7] &&
        ((addr[15:8] & global_low) == global_low);
endmodule // msd_addr_class

// ===== msd_core_model.sv
// Core-side bus model issuing fetches, data accesses and status loads
module msd_core_model (
    input  logic        clk,
    output logic        prog_req,
    output logic [15:0] program_address_bus,
    output logic        io_req,
    output logic        rd_req,
    output logic        rd_direct,
    output logic [6:0]  rd_offset,
    output logic [15:0] data_read_address_bus,
    output logic        wr_req,
    output logic        wr_direct,
    output logic [6:0]  wr_offset,
    output logic [15:0] data_write_address_bus,
    output logic [15:0] wr_data,
    output logic [15:0] status_word_one,
    output logic [15:0] status_word_zero,
    output logic        status_wr,
    output logic [15:0] int_set
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {prog_req, io_req, rd_req, rd_direct, wr_req, wr_direct} = 6'h00;
        {program_address_bus, data_read_address_bus} = 32'h0;
        {data_write_address_bus, wr_data, int_set} = 48'h0;
        {status_word_one, status_word_zero, rd_offset, wr_offset} = 46'h0;
        status_wr = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One cycle on all three buses at once; released address buses and write data
    // show the inverse, while the offsets and the direct flags keep their values
    task automatic go(input logic f, input logic [15:0] pa, input logic r,
                      input logic [15:0] ra, input logic w,
                      input logic [15:0] wa, input logic [15:0] wd,
                      input logic d, input logic io);
        @(negedge clk);
        {prog_req, rd_req, wr_req, io_req, rd_direct, wr_direct} =
            {f, r, w, io, d, d};
        program_address_bus = pa;
        data_read_address_bus = ra;
        rd_offset = ra[6:0];
        data_write_address_bus = wa;
        wr_offset = wa[6:0];
        wr_data = wd;
        @(negedge clk);
        {prog_req, rd_req, wr_req, io_req} = 4'h0;
        program_address_bus = ~pa;
        data_read_address_bus = ~ra;
        data_write_address_bus = ~wa;
        wr_data = ~wd;
    endtask
    // Status word load, one-cycle strobe
    task automatic st(input logic [15:0] s1, input logic [15:0] s0);
        @(negedge clk);
        status_word_one = s1;
        status_word_zero = s0;
        status_wr = 1'b1;
        @(negedge clk);
        status_wr = 1'b0;
    endtask
    // Hardware pending-set pulse
    task automatic irq(input logic [15:0] v);
        @(negedge clk);
        int_set = v;
        @(negedge clk);
        int_set = 16'h0000;
    endtask
endmodule // msd_core_model

// ===== msd_map.vh
// Address map, field positions and reset values for the memory space decoder
`ifndef MSD_MAP_VH
`define MSD_MAP_VH
`define MSD_ADDR_W          16
`define MSD_CNF_BIT         12
`define MSD_DP_LSB          0
`define MSD_DP_W            9
`define MSD_OFS_W           7
`define MSD_PAGE0_HI        16'h007f
`define MSD_RSV0_LO         16'h0000
`define MSD_RSV0_HI         16'h0003
`define MSD_INT_MASK_ADDR   16'h0004
`define MSD_GLOBAL_SZ_ADDR  16'h0005
`define MSD_INT_PEND_ADDR   16'h0006
`define MSD_RSV1_LO         16'h0023
`define MSD_RSV1_HI         16'h0027
`define MSD_TEST_LO         16'h002b
`define MSD_TEST_HI         16'h002f
`define MSD_SCR_LO          16'h0060
`define MSD_SCR_HI          16'h007f
`define MSD_SCR_WORDS       32
`define MSD_GLOBAL_BASE     16'h8000
`define MSD_RESET_VECTOR    16'h0000
`define MSD_REG_RESET       16'h0000
`define MSD_B0_BASE         16'h0200
`define MSD_B1_BASE         16'h0300
`define MSD_B_WORDS         256
`define MSD_SARAM_BASE      16'h0800
`define MSD_SARAM_WORDS     2048
`define MSD_ROM_WORDS       16'h4000
`endif

// ===== msd_memory_space_decoder.v
// Top of the memory space decoder: bus steering and page-zero registers
`include "msd_map.vh"

////////////////////////////////////////////////////////////////////////////
module msd_memory_space_decoder (
    input  wire        clk,
    input  wire        srst,
    input  wire        boot_source_pin,
    input  wire        shared_ram_pin,
    input  wire [15:0] status_word_one,
    input  wire [15:0] status_word_zero,
    input  wire        status_wr,
    input  wire        prog_req,
    input  wire [15:0] program_address_bus,
    input  wire        io_req,
    input  wire        rd_req,
    input  wire        rd_direct,
    input  wire [6:0]  rd_offset,
    input  wire [15:0] data_read_address_bus,
    input  wire        wr_req,
    input  wire        wr_direct,
    input  wire [6:0]  wr_offset,
    input  wire [15:0] data_write_address_bus,
    input  wire [15:0] wr_data,
    input  wire [15:0] int_set,
    output reg  [15:0] rd_data,
    output reg         rd_valid,
    output reg  [15:0] prog_addr_q,
    output reg         prog_sel_b0,
    output reg         prog_sel_saram,
    output reg         prog_sel_rom,
    output reg         prog_ext_n,
    output reg         data_space_strobe_n,
    output reg         global_access_strobe_n,
    output reg         io_strobe_n,
    output reg         data_ext,
    output reg  [15:0] data_ext_addr,
    output reg  [2:0]  rd_target,
    output reg  [2:0]  wr_target,
    output reg         prog_ram_select_q,
    output reg  [15:0] interrupt_mask_q,
    output reg  [15:0] global_space_size_q,
    output reg  [15:0] interrupt_pending_q
);
    // Target codes for a data access
    localparam T_NONE  = 3'h0;
    localparam T_REG   = 3'h1;
    localparam T_SCR   = 3'h2;
    localparam T_B0    = 3'h3;
    localparam T_B1    = 3'h4;
    localparam T_SARAM = 3'h5;
    localparam T_EXT   = 3'h6;

    reg         boot_s1_reg;
    reg         boot_s2_reg;
    reg         boot_s3_reg;
    reg         boot_mode_reg;
    reg         shr_s1_reg;
    reg         shr_s2_reg;
    reg         shr_s3_reg;
    reg         shared_reg;
    reg         first_fetch_reg;
    reg  [15:0] int_pend_next;

    ////////////////////////////////////////////////////////////////////////
    // Direct address: page pointer over the instruction offset
    function [15:0] msd_dir_addr;
        input [15:0] st0;
        input [6:0]  ofs;
        begin
            msd_dir_addr = {st0[`MSD_DP_LSB +: `MSD_DP_W], ofs};
        end
    endfunction

    // Page-zero holes that read zero and drop writes
    function msd_reserved;
        input [15:0] a;
        begin
            msd_reserved = (a <= `MSD_RSV0_HI) ||
                (a >= `MSD_RSV1_LO && a <= `MSD_RSV1_HI) ||
                (a >= `MSD_TEST_LO && a <= `MSD_TEST_HI);
        end
    endfunction

    // Chooses a target code from the class flags
    function [2:0] msd_target;
        input p0;
        input scr;
        input b0;
        input b1;
        input sa;
        begin
            if (scr) begin
                msd_target = T_SCR;
            end else if (p0) begin
                msd_target = T_REG;
            end else if (b0) begin
                msd_target = T_B0;
            end else if (b1) begin
                msd_target = T_B1;
            end else if (sa) begin
                msd_target = T_SARAM;
            end else begin
                msd_target = T_EXT;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Effective addresses; both data buses resolved in parallel
    wire [15:0] rd_addr = rd_direct ?
        msd_dir_addr(status_word_zero, rd_offset) : data_read_address_bus;
    wire [15:0] wr_addr = wr_direct ?
        msd_dir_addr(status_word_zero, wr_offset) : data_write_address_bus;

    wire r_b0, r_b1, r_scr, r_sa, r_p0, r_gl;
    wire w_b0, w_b1, w_scr, w_sa, w_p0, w_gl;

    // One classifier per data bus so read and write share no decoder
    msd_addr_class u_rd_class (
        .addr           (rd_addr),
        .prog_ram_sel   (prog_ram_select_q),
        .shared_ram_pin (shared_reg),
        .global_low     (global_space_size_q[7:0]),
        .hit_b0         (r_b0),
        .hit_b1         (r_b1),
        .hit_scr        (r_scr),
        .hit_saram      (r_sa),
        .hit_page0      (r_p0),
        .is_global      (r_gl)
    );

    msd_addr_class u_wr_class (
        .addr           (wr_addr),
        .prog_ram_sel   (prog_ram_select_q),
        .shared_ram_pin (shared_reg),
        .global_low     (global_space_size_q[7:0]),
        .hit_b0         (w_b0),
        .hit_b1         (w_b1),
        .hit_scr        (w_scr),
        .hit_saram      (w_sa),
        .hit_page0      (w_p0),
        .is_global      (w_gl)
    );

    wire [2:0] rd_tgt = msd_target(r_p0, r_scr, r_b0, r_b1, r_sa);
    wire [2:0] wr_tgt = msd_target(w_p0, w_scr, w_b0, w_b1, w_sa);

    // Scratch block is dual-access: a read and a write in one cycle
    wire        scr_we = wr_req && wr_tgt == T_SCR;
    wire [15:0] scr_rdata;
    msd_scratch_ram #(
        .WORDS (`MSD_SCR_WORDS),
        .AW    (5)
    ) u_scratch (
        .clk   (clk),
        .we    (scr_we),
        .waddr (wr_addr[4:0]),
        .wdata (wr_data),
        .raddr (rd_addr[4:0]),
        .rdata (scr_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program space decode (combinational, registered below)
    wire p_b0 = prog_ram_select_q && program_address_bus >= `MSD_B0_BASE &&
        program_address_bus < `MSD_B0_BASE + `MSD_B_WORDS;
    wire p_in_sa = program_address_bus >= `MSD_SARAM_BASE &&
        program_address_bus < `MSD_SARAM_BASE + `MSD_SARAM_WORDS;
    wire p_sa = shared_reg && p_in_sa;
    // Boot ROM sits low in program space only in microcomputer mode; the
    // RAM windows punch holes in it, so with the shared pin low the shared
    // range goes off chip instead of landing in ROM
    wire p_rom = !boot_mode_reg && !p_b0 && !p_in_sa &&
        program_address_bus < `MSD_ROM_WORDS;
    wire [15:0] p_addr = first_fetch_reg ? `MSD_RESET_VECTOR :
        program_address_bus;
    wire p_rom_eff = first_fetch_reg ? !boot_mode_reg : p_rom;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers run through reset, so the straps are settled by
    // release; a change counts when stages two and three agree
    always @(posedge clk) begin
        boot_s1_reg <= boot_source_pin;
        boot_s2_reg <= boot_s1_reg;
        boot_s3_reg <= boot_s2_reg;
        shr_s1_reg  <= shared_ram_pin;
        shr_s2_reg  <= shr_s1_reg;
        shr_s3_reg  <= shr_s2_reg;
        if (shr_s2_reg == shr_s3_reg) begin
            shared_reg <= shr_s3_reg;
        end
    end

    // Boot strap follows the pin in reset and until the first fetch
    always @(posedge clk) begin
        if ((srst || first_fetch_reg) && boot_s2_reg == boot_s3_reg) begin
            boot_mode_reg <= boot_s3_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration bit and page-zero registers
    always @* begin
        int_pend_next = interrupt_pending_q;
        if (wr_req && wr_addr == `MSD_INT_PEND_ADDR) begin
            int_pend_next = int_pend_next & ~wr_data;
        end
        // New events win over a clear in the same cycle
        int_pend_next = int_pend_next | int_set;
    end

    always @(posedge clk) begin
        if (srst) begin
            prog_ram_select_q   <= 1'b0;
            interrupt_mask_q    <= `MSD_REG_RESET;
            global_space_size_q <= `MSD_REG_RESET;
            interrupt_pending_q <= `MSD_REG_RESET;
        end else begin
            if (status_wr) begin
                prog_ram_select_q <= status_word_one[`MSD_CNF_BIT];
            end
            // Zero-wait writes; reserved holes have no storage at all
            if (wr_req && wr_addr == `MSD_INT_MASK_ADDR) begin
                interrupt_mask_q <= wr_data;
            end
            if (wr_req && wr_addr == `MSD_GLOBAL_SZ_ADDR) begin
                global_space_size_q <= wr_data;
            end
            interrupt_pending_q <= int_pend_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs: one cycle from request to strobes and data
    always @(posedge clk) begin
        if (srst) begin
            first_fetch_reg        <= 1'b1;
            rd_data                <= 16'h0000;
            rd_valid               <= 1'b0;
            prog_addr_q            <= `MSD_RESET_VECTOR;
            prog_sel_b0            <= 1'b0;
            prog_sel_saram         <= 1'b0;
            prog_sel_rom           <= 1'b0;
            prog_ext_n             <= 1'b1;
            data_space_strobe_n    <= 1'b1;
            global_access_strobe_n <= 1'b1;
            io_strobe_n            <= 1'b1;
            data_ext               <= 1'b0;
            data_ext_addr          <= 16'h0000;
            rd_target              <= T_NONE;
            wr_target              <= T_NONE;
        end else begin
            if (prog_req) begin
                first_fetch_reg <= 1'b0;
            end
            // Program side; anything not on chip goes out
            prog_addr_q    <= p_addr;
            prog_sel_b0    <= prog_req && !first_fetch_reg && p_b0;
            prog_sel_saram <= prog_req && !first_fetch_reg && p_sa;
            prog_sel_rom   <= prog_req && p_rom_eff;
            prog_ext_n     <= !(prog_req && !p_rom_eff && (first_fetch_reg ||
                              (!p_b0 && !p_sa)));
            // I/O space has its own strobe, kept apart from data
            io_strobe_n <= !io_req;
            data_space_strobe_n <= !((rd_req || wr_req) && !io_req);
            global_access_strobe_n <= !(!io_req &&
                ((rd_req && r_gl) || (wr_req && w_gl)));
            rd_target <= rd_req ? rd_tgt : T_NONE;
            wr_target <= wr_req ? wr_tgt : T_NONE;
            data_ext  <= (rd_req && rd_tgt == T_EXT) ||
                         (wr_req && wr_tgt == T_EXT);
            data_ext_addr <= (rd_req && rd_tgt == T_EXT) ? rd_addr : wr_addr;
            // Read mux: registers and scratch here, reserved reads zero
            rd_valid <= rd_req && (rd_tgt == T_REG || rd_tgt == T_SCR);
            if (rd_req && rd_tgt == T_SCR) begin
                rd_data <= scr_rdata;
            end else if (rd_req && rd_tgt == T_REG &&
                         !msd_reserved(rd_addr)) begin
                case (rd_addr)
                    `MSD_INT_MASK_ADDR:  rd_data <= interrupt_mask_q;
                    `MSD_GLOBAL_SZ_ADDR: rd_data <= global_space_size_q;
                    `MSD_INT_PEND_ADDR:  rd_data <= interrupt_pending_q;
                    default:             rd_data <= 16'h0000;
                endcase
            end else begin
                rd_data <= 16'h0000;
            end
        end
    end
endmodule // msd_memory_space_decoder

// ===== msd_memory_space_decoder_assertions.sv
// Concurrent checks on the ports of the memory space decoder
module msd_checker (
    input logic        clk,
    input logic        srst,
    input logic [15:0] status_word_one,
    input logic [15:0] status_word_zero,
    input logic        status_wr,
    input logic        prog_req,
    input logic [15:0] program_address_bus,
    input logic        io_req,
    input logic        rd_req,
    input logic        rd_direct,
    input logic [6:0]  rd_offset,
    input logic [15:0] data_read_address_bus,
    input logic        wr_req,
    input logic        wr_direct,
    input logic [15:0] data_write_address_bus,
    input logic [15:0] rd_data,
    input logic        rd_valid,
    input logic [15:0] prog_addr_q,
    input logic        prog_sel_b0,
    input logic        prog_ext_n,
    input logic        data_space_strobe_n,
    input logic        global_access_strobe_n,
    input logic        io_strobe_n,
    input logic [2:0]  rd_target,
    input logic        prog_ram_select_q,
    input logic [15:0] interrupt_mask_q,
    input logic [15:0] global_space_size_q
);
    logic [15:0] rd_ea;
    logic        rd_rsv;
    logic        rd_glob;
    logic        fetched_reg;
    // Effective read address, page pointer above offset when direct
    assign rd_ea = rd_direct ? {status_word_zero[8:0], rd_offset}
                             : data_read_address_bus;
    assign rd_rsv = rd_ea <= 16'h0003 ||
        (rd_ea >= 16'h0023 && rd_ea <= 16'h0027) ||
        (rd_ea >= 16'h002b && rd_ea <= 16'h002f);
    assign rd_glob = global_space_size_q[7] &&
        ((rd_ea[15:8] & global_space_size_q[7:0]) == global_space_size_q[7:0]);
    // The first fetch is forced to zero, so later fetch checks skip it
    always @(posedge clk) begin
        if (srst) fetched_reg <= 1'b0;
        else if (prog_req) fetched_reg <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    rst_idle_a: assert property (disable iff (1'b0) srst |=>
        data_space_strobe_n && io_strobe_n && !prog_ram_select_q)
        else $error("strobes or select not idle after reset");
    sel_load_a: assert property (status_wr |=>
        prog_ram_select_q == $past(status_word_one[12]))
        else $error("program ram select not loaded");
    first_fetch_a: assert property (prog_req && !fetched_reg |=>
        prog_addr_q == 16'h0000) else $error("first fetch not at zero");
    b0_prog_a: assert property (prog_req && fetched_reg &&
        program_address_bus[15:8] == 8'h02 |=>
        prog_sel_b0 == $past(prog_ram_select_q))
        else $error("block zero program select wrong");
    ext_fetch_a: assert property (prog_req && fetched_reg &&
        program_address_bus[15] |=> !prog_ext_n && !prog_sel_b0)
        else $error("high fetch not external");
    ds_read_a: assert property (rd_req && !io_req |=>
        !data_space_strobe_n) else $error("data strobe missing");
    glob_strobe_a: assert property (rd_req && !io_req &&
        !wr_req |=>
        global_access_strobe_n == !$past(rd_glob))
        else $error("global strobe wrong");
    io_space_a: assert property (rd_req && io_req && !wr_req |=>
        !io_strobe_n && data_space_strobe_n) else $error("io strobe wrong");
    reg_read_a: assert property (rd_req && !io_req &&
        rd_ea == 16'h0005 |=>
        rd_valid && rd_target == 3'h1 && rd_data == $past(global_space_size_q))
        else $error("global size read wrong");
    rsv_read_a: assert property (rd_req && !io_req &&
        rd_rsv |=>
        rd_valid && rd_data == 16'h0000) else $error("reserved read not zero");
    rsv_write_a: assert property (wr_req && !io_req &&
        !wr_direct &&
        data_write_address_bus <= 16'h0003 |=>
        $stable(interrupt_mask_q) && $stable(global_space_size_q))
        else $error("reserved write disturbed registers");
    scr_read_a: assert property (rd_req && !io_req &&
        rd_ea[15:5] == 11'h003 |=> rd_valid && rd_target == 3'h2)
        else $error("scratch read not decoded");
    cover property (prog_req && !fetched_reg);
    cover property (status_wr && status_word_one[12]);
    cover property (rd_req && rd_glob);
endmodule // msd_checker

bind msd_memory_space_decoder msd_checker u_msd_checker (.*);

// ===== msd_scratch_ram.v
// Dual-access scratch RAM: one read port and one write port per cycle
`include "msd_map.vh"
module msd_scratch_ram #(
    parameter WORDS = `MSD_SCR_WORDS,
    parameter AW    = 5
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [15:0]   wdata,
    input  wire [AW-1:0] raddr,
    output wire [15:0]   rdata
);
    reg [15:0] mem [0:WORDS-1];

    // Write port; read is combinational so both happen in one cycle
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    assign rdata = mem[raddr];
endmodule // msd_scratch_ram

// ===== tb_msd_memory_space_decoder.sv
// Self-checking bench for the memory space decoder
module tb_msd_memory_space_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, srst, boot_source_pin, shared_ram_pin, status_wr;
    logic        prog_req, io_req, rd_req, rd_direct, wr_req, wr_direct;
    logic [6:0]  rd_offset, wr_offset;
    logic [15:0] program_address_bus, data_read_address_bus, wr_data;
    logic [15:0] data_write_address_bus, int_set;
    logic [15:0] status_word_one, status_word_zero, data_ext_addr;
    logic [15:0] rd_data, prog_addr_q, interrupt_mask_q;
    logic [15:0] global_space_size_q, interrupt_pending_q;
    logic        rd_valid, prog_sel_b0, prog_sel_saram, prog_sel_rom;
    logic        prog_ext_n, data_space_strobe_n, global_access_strobe_n;
    logic        io_strobe_n, data_ext, prog_ram_select_q;
    logic [2:0]  rd_target, wr_target;
    int          errors = 0;
    int          checks = 0;
    msd_memory_space_decoder u_msd_memory_space_decoder (.*);
    msd_core_model u_msd_core_model (.*);
    initial clk = 1'b0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // Compare and access helpers
    task automatic chk(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic d = 1'b0);
        u_msd_core_model.go(1'b0, 16'h0000, 1'b1, a, 1'b0, 16'h0000,
                            16'h0000, d, 1'b0);
    endtask
    task automatic wr(input logic [15:0] a, d, input logic dir = 1'b0);
        u_msd_core_model.go(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, a, d,
                            dir, 1'b0);
    endtask
    task automatic fe(input logic [15:0] a);
        u_msd_core_model.go(1'b1, a, 1'b0, 16'h0000, 1'b0, 16'h0000,
                            16'h0000, 1'b0, 1'b0);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog: the run needs well under ten thousand cycles
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; pins settle through a three-stage synchroniser
    initial begin
        {srst, boot_source_pin, shared_ram_pin} = 3'b101;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        chk("sel", {15'h0, prog_ram_select_q}, 16'h0000);
        fe(16'h1234);
        chk("paddr", prog_addr_q, 16'h0000);
        chk("rom", {15'h0, prog_sel_rom}, 16'h0001);
        $display("test boot rom done");
        wr(16'h0004, 16'h00ff);
        chk("maskq", interrupt_mask_q, 16'h00ff);
        wr(16'h0005, 16'h00e0);
        rd(16'h0004);
        chk("mask", rd_data, 16'h00ff);
        u_msd_core_model.irq(16'h0003);
        wr(16'h0006, 16'h0001);
        chk("pendq", interrupt_pending_q, 16'h0002);
        rd(16'h0006);
        chk("pend", rd_data, 16'h0002);
        // Test area is never written here, a write could change modes
        wr(16'h0001, 16'hffff);
        wr(16'h0025, 16'hffff);
        chk("maskr", interrupt_mask_q, 16'h00ff);
        rd(16'h0025);
        chk("rsv", rd_data, 16'h0000);
        chk("rsvv", {15'h0, rd_valid}, 16'h0001);
        rd(16'h002c);
        chk("test", rd_data, 16'h0000);
        rd(16'h0005);
        chk("gsize", rd_data, 16'h00e0);
        $display("test registers done");
        rd(16'he000);
        chk("glob", {15'h0, global_access_strobe_n}, 16'h0000);
        chk("ds", {15'h0, data_space_strobe_n}, 16'h0000);
        rd(16'hd000);
        chk("local", {15'h0, global_access_strobe_n}, 16'h0001);
        $display("test global done");
        u_msd_core_model.st(16'h0000, 16'h0000);
        wr(16'h0060, 16'ha5a5, 1'b1);
        wr(16'h007f, 16'h5a5a);
        chk("wtgt", {13'h0, wr_target}, 16'h0002);
        rd(16'h0060, 1'b1);
        chk("scr0", rd_data, 16'ha5a5);
        rd(16'h007f);
        chk("scr1", rd_data, 16'h5a5a);
        u_msd_core_model.st(16'h0000, 16'h0001);
        rd(16'h0005, 1'b1);
        chk("page1", {13'h0, rd_target}, 16'h0006);
        chk("daddr", data_ext_addr, 16'h0085);
        chk("dext", {15'h0, data_ext}, 16'h0001);
        $display("test scratch done");
        u_msd_core_model.st(16'h1000, 16'h0000);
        fe(16'h0200);
        chk("b0p", {15'h0, prog_sel_b0}, 16'h0001);
        rd(16'h0200);
        chk("b0ext", {13'h0, rd_target}, 16'h0006);
        rd(16'h0300);
        chk("b1", {13'h0, rd_target}, 16'h0004);
        u_msd_core_model.st(16'h0000, 16'h0000);
        fe(16'h0200);
        chk("b0off", {15'h0, prog_sel_b0}, 16'h0000);
        rd(16'h0200);
        chk("b0d", {13'h0, rd_target}, 16'h0003);
        $display("test block zero done");
        fe(16'h0800);
        chk("sap", {15'h0, prog_sel_saram}, 16'h0001);
        rd(16'h0800);
        chk("sad", {13'h0, rd_target}, 16'h0005);
        shared_ram_pin = 1'b0;
        repeat (5) @(negedge clk);
        fe(16'h0800);
        chk("saxp", {15'h0, prog_ext_n}, 16'h0000);
        rd(16'h0800);
        chk("saxd", {13'h0, rd_target}, 16'h0006);
        $display("test shared ram done");
        u_msd_core_model.go(1'b1, 16'h9000, 1'b1, 16'h0004, 1'b0,
                            16'h0000, 16'h0000, 1'b0, 1'b0);
        chk("extf", {15'h0, prog_ext_n}, 16'h0000);
        chk("para", rd_data, 16'h00ff);
        u_msd_core_model.go(1'b0, 16'h0000, 1'b1, 16'h0005, 1'b0,
                            16'h0000, 16'h0000, 1'b0, 1'b1);
        chk("io", {14'h0, io_strobe_n, data_space_strobe_n},
            16'h0001);
        $display("test parallel done");
        u_msd_core_model.st(16'h1000, 16'h0000);
        {srst, boot_source_pin} = 2'b11;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        chk("sel2", {15'h0, prog_ram_select_q}, 16'h0000);
        fe(16'h0000);
        chk("extb", {14'h0, prog_ext_n, prog_sel_rom}, 16'h0000);
        $display("test external boot done");
        report_and_stop;
    end
endmodule // tb_msd_memory_space_decoder
